/* hw/rft_pkg.sv */
// constants, types and code tables for the repeat-frame rf transceiver
// assumes a 100 MHz system clock and a 2400 bit/s on-air rate
package rft_pkg;
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned BAUD_BPS       = 2400;
    // bit period in clocks, integer division so it rounds down
    localparam int unsigned BIT_CYC        = CLK_HZ / BAUD_BPS;
    // receive sample point at three quarters of a bit period
    localparam int unsigned SAMPLE_CYC     = (BIT_CYC * 3) / 4;
    localparam int unsigned GAP_BITS       = 40;
    localparam int unsigned GAP_CYC        = BIT_CYC * GAP_BITS;
    localparam int unsigned DISPLAY_MS     = 1000;
    localparam int unsigned DISPLAY_CYC    = (CLK_HZ / 1000) * DISPLAY_MS;
    localparam int unsigned LCD_HALF_MS    = 16;
    localparam int unsigned LCD_HALF_CYC   = (CLK_HZ / 1000) * LCD_HALF_MS;

    localparam int unsigned FRAME_BITS     = 36;
    localparam int unsigned FIELD_BITS     = 12;
    localparam int unsigned SYM_BITS       = 6;
    localparam int unsigned REPEATS        = 4;
    localparam int unsigned NUM_STATES     = 8;
    // frame field positions inside the 36-bit vector, bit 0 goes out first
    localparam int unsigned PRE_LSB        = 0;
    localparam int unsigned PAY_LSB        = 12;
    localparam int unsigned POST_LSB       = 24;

    localparam logic [11:0] PREAMBLE       = 12'h555;
    localparam logic [11:0] POSTAMBLE      = 12'hCCC;
    localparam logic        TX_MODE_LEVEL  = 1'h1;
    localparam logic        RX_MODE_LEVEL  = 1'h0;
    localparam logic        LINE_IDLE      = 1'h0;

    localparam int unsigned CNT_W          = 24;
    localparam int unsigned DISP_W         = 27;

    typedef struct packed {
        logic [3:0] hi;
        logic [3:0] lo;
    } rft_digits_t;

    typedef enum logic [1:0] {
        RFT_TX_IDLE  = 2'h0,
        RFT_TX_SHIFT = 2'h1,
        RFT_TX_DONE  = 2'h3
    } rft_tx_state_t;

    // sixteen symbols, runs of at most two inside and at each end
    // no 0x30-0x33 symbol: its 0011 tail plus the postamble would end a frame early
    localparam logic [5:0] SYM_TABLE [16] = '{
        6'h0B, 6'h0D, 6'h13, 6'h15, 6'h16, 6'h19, 6'h1A, 6'h25,
        6'h26, 6'h29, 6'h2A, 6'h2C, 6'h2D, 6'h34, 6'h1B, 6'h24
    };
endpackage

/* hw/rft_transceiver.sv */
// repeat-frame rf transceiver: transmit framer and receive deframer with vote
// assumes rf data pins are asynchronous; one system clock, synchronous reset
`timescale 1ns/1ps

// Notes on behaviour
// - every frame is 36 bits: preamble, payload, postamble
// - each payload goes out four times; receiver compares the copies
// - digits use sixteen six-bit symbols, never more than four equal bits in a row
// - display timer drives lcd common line and pulses advance at interval end
// - each state picks two digits from its number; the digits index the symbol table
// - on advance, step state number, then pulse load so sender latches payload
// - sequencer issues four spaced loads per state, spacing sets the frame gap
// - on load, sender latches payload and shifts the frame one bit per period
// - transmit mode-select output holds the rf transmit level
// - receive pin enters a three-bit history register every clock
// - a transition in the low history bits enables the sampling counter
// - counter reaches three quarters of a bit, samples into 36-bit register
// - without new edges the counter keeps running, sampling each next bit
// - every further edge restarts the sampling counter to limit drift
// - postamble in top 12 bits stores payload in next capture copy, rearms
// - after four copies, two equal copies are decoded and shown
// - receive mode-select output holds the rf receive level
// - one system clock and one active-low global reset run both sides
// - sampling counter terminal value follows the bit rate
// - each received six-bit table symbol maps to a four-bit digit; any other symbol flags invalid
module rft_transceiver #(
    parameter int unsigned BIT_CYC      = rft_pkg::BIT_CYC,
    parameter int unsigned SAMPLE_CYC   = rft_pkg::SAMPLE_CYC,
    parameter int unsigned GAP_CYC      = rft_pkg::GAP_CYC,
    parameter int unsigned DISPLAY_CYC  = rft_pkg::DISPLAY_CYC,
    parameter int unsigned LCD_HALF_CYC = rft_pkg::LCD_HALF_CYC
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                rx_pin,
    output logic                     tx_pin,
    output logic                     tx_rf_mode,
    output logic                     rx_rf_mode,
    output logic                     lcd_common_line,
    output rft_pkg::rft_digits_t     tx_digits,
    output rft_pkg::rft_digits_t     rx_digits,
    output logic                     rx_update
);
    localparam logic [rft_pkg::CNT_W-1:0]  BIT_LAST    = rft_pkg::CNT_W'(BIT_CYC - 1);
    localparam logic [rft_pkg::CNT_W-1:0]  SAMPLE_LAST = rft_pkg::CNT_W'(SAMPLE_CYC - 1);
    localparam logic [rft_pkg::CNT_W-1:0]  GAP_LAST    = rft_pkg::CNT_W'(GAP_CYC - 1);
    localparam logic [rft_pkg::DISP_W-1:0] DISP_LAST   = rft_pkg::DISP_W'(DISPLAY_CYC - 1);
    localparam logic [rft_pkg::DISP_W-1:0] LCD_LAST    = rft_pkg::DISP_W'(LCD_HALF_CYC - 1);

    function automatic logic [5:0] nibble_to_symbol(input logic [3:0] n);
        return rft_pkg::SYM_TABLE[n];
    endfunction

    // unknown symbols flag invalid so a corrupted copy never reaches the display
    function automatic logic [4:0] symbol_to_nibble(input logic [5:0] s);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (rft_pkg::SYM_TABLE[i] == s) begin
                r = {1'h1, 4'(i)};
            end
        end
        return r;
    endfunction

    function automatic rft_pkg::rft_digits_t state_digits(input logic [2:0] st);
        rft_pkg::rft_digits_t d;
        d.hi = {st, 1'h0};
        d.lo = {st, 1'h1};
        return d;
    endfunction

    // ---------------- display timer ----------------
    logic [rft_pkg::DISP_W-1:0] disp_cnt_reg, disp_cnt_next;
    logic [rft_pkg::DISP_W-1:0] lcd_cnt_reg, lcd_cnt_next;
    logic                       lcd_reg, lcd_next;
    logic                       advance_reg, advance_next;

    always_comb begin
        disp_cnt_next = disp_cnt_reg + 1'h1;
        advance_next  = 1'h0;
        lcd_cnt_next  = lcd_cnt_reg + 1'h1;
        lcd_next      = lcd_reg;
        if (disp_cnt_reg == DISP_LAST) begin
            disp_cnt_next = '0;
            advance_next  = 1'h1;
        end
        if (lcd_cnt_reg == LCD_LAST) begin
            lcd_cnt_next = '0;
            lcd_next     = ~lcd_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            disp_cnt_reg <= '0;
            lcd_cnt_reg  <= '0;
            lcd_reg      <= 1'h0;
            advance_reg  <= 1'h0;
        end else begin
            disp_cnt_reg <= disp_cnt_next;
            lcd_cnt_reg  <= lcd_cnt_next;
            lcd_reg      <= lcd_next;
            advance_reg  <= advance_next;
        end
    end

    // ---------------- state sequencer ----------------
    logic [2:0]               state_number_reg, state_number_next;
    logic [1:0]               repeat_reg, repeat_next;
    logic                     repeating_reg, repeating_next;
    logic [rft_pkg::CNT_W-1:0] gap_cnt_reg, gap_cnt_next;
    logic                     load_reg, load_next;
    rft_pkg::rft_digits_t     cur_digits;
    logic [11:0]              state_payload;

    always_comb begin
        cur_digits    = state_digits(state_number_reg);
        state_payload = {nibble_to_symbol(cur_digits.hi),
                         nibble_to_symbol(cur_digits.lo)};
    end

    always_comb begin
        state_number_next = state_number_reg;
        repeat_next       = repeat_reg;
        repeating_next    = repeating_reg;
        gap_cnt_next      = gap_cnt_reg;
        load_next         = 1'h0;
        if (advance_reg) begin
            state_number_next = state_number_reg + 1'h1;
            repeat_next       = 2'h0;
            repeating_next    = 1'h1;
            gap_cnt_next      = GAP_LAST; // first load one cycle after the new number
        end else if (repeating_reg) begin
            if (gap_cnt_reg == GAP_LAST) begin
                gap_cnt_next = '0;
                load_next    = 1'h1;
                repeat_next  = repeat_reg + 1'h1;
                if (repeat_reg == 2'(rft_pkg::REPEATS - 1)) begin
                    repeating_next = 1'h0;
                end
            end else begin
                gap_cnt_next = gap_cnt_reg + 1'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_number_reg <= 3'h0;
            repeat_reg       <= 2'h0;
            repeating_reg    <= 1'h0;
            gap_cnt_reg      <= '0;
            load_reg         <= 1'h0;
        end else begin
            state_number_reg <= state_number_next;
            repeat_reg       <= repeat_next;
            repeating_reg    <= repeating_next;
            gap_cnt_reg      <= gap_cnt_next;
            load_reg         <= load_next;
        end
    end

    // ---------------- serial sender ----------------
    // a load that lands mid-frame is dropped; the gap is sized to avoid that
    rft_pkg::rft_tx_state_t    tx_state_reg, tx_state_next;
    logic [35:0]               tx_shift_reg, tx_shift_next;
    logic [5:0]                tx_bits_reg, tx_bits_next;
    logic [rft_pkg::CNT_W-1:0] tx_cnt_reg, tx_cnt_next;
    logic                      tx_pin_next;
    rft_pkg::rft_digits_t      tx_digits_next;

    always_comb begin
        tx_state_next  = tx_state_reg;
        tx_shift_next  = tx_shift_reg;
        tx_bits_next   = tx_bits_reg;
        tx_cnt_next    = tx_cnt_reg;
        tx_pin_next    = tx_pin;
        tx_digits_next = tx_digits;
        case (tx_state_reg)
            rft_pkg::RFT_TX_IDLE: begin
                tx_pin_next = rft_pkg::LINE_IDLE;
                if (load_reg) begin
                    tx_shift_next  = {rft_pkg::POSTAMBLE, state_payload,
                                      rft_pkg::PREAMBLE};
                    tx_digits_next = cur_digits;
                    tx_bits_next   = '0;
                    tx_cnt_next    = '0;
                    tx_state_next  = rft_pkg::RFT_TX_SHIFT;
                end
            end
            rft_pkg::RFT_TX_SHIFT: begin
                tx_pin_next = tx_shift_reg[0];
                if (tx_cnt_reg == BIT_LAST) begin
                    tx_cnt_next   = '0;
                    tx_shift_next = {1'h0, tx_shift_reg[35:1]};
                    tx_bits_next  = tx_bits_reg + 1'h1;
                    if (tx_bits_reg == 6'(rft_pkg::FRAME_BITS - 1)) begin
                        tx_state_next = rft_pkg::RFT_TX_DONE;
                    end
                end else begin
                    tx_cnt_next = tx_cnt_reg + 1'h1;
                end
            end
            rft_pkg::RFT_TX_DONE: begin
                tx_pin_next   = rft_pkg::LINE_IDLE;
                tx_state_next = rft_pkg::RFT_TX_IDLE;
            end
            default: begin
                tx_state_next = rft_pkg::RFT_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_state_reg <= rft_pkg::RFT_TX_IDLE;
            tx_shift_reg <= '0;
            tx_bits_reg  <= '0;
            tx_cnt_reg   <= '0;
            tx_pin       <= rft_pkg::LINE_IDLE;
            tx_digits    <= '0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= tx_shift_next;
            tx_bits_reg  <= tx_bits_next;
            tx_cnt_reg   <= tx_cnt_next;
            tx_pin       <= tx_pin_next;
            tx_digits    <= tx_digits_next;
        end
    end

    // ---------------- receiver ----------------
    logic                      rx_meta_reg, rx_sync_reg;
    logic [2:0]                rx_edge_history;
    logic                      rx_edge;
    logic                      samp_en_reg, samp_en_next;
    logic [rft_pkg::CNT_W-1:0] samp_cnt_reg, samp_cnt_next;
    logic [35:0]               rx_shift_reg, rx_shift_next;
    logic [11:0]               capture_copy [4];
    logic [11:0]               capture_next [4];
    logic [1:0]                cap_idx_reg, cap_idx_next;
    rft_pkg::rft_digits_t      rx_digits_next;
    logic                      rx_update_next;
    logic [35:0]               shifted;
    logic [11:0]               winner;
    logic                      agree;
    logic [4:0]                dec_hi, dec_lo;

    assign rx_edge = rx_edge_history[1] ^ rx_edge_history[0];

    always_comb begin
        samp_en_next   = samp_en_reg;
        samp_cnt_next  = samp_cnt_reg;
        rx_shift_next  = rx_shift_reg;
        cap_idx_next   = cap_idx_reg;
        rx_digits_next = rx_digits;
        rx_update_next = 1'h0;
        capture_next   = capture_copy;
        shifted        = {rx_edge_history[0], rx_shift_reg[35:1]};
        winner         = '0;
        agree          = 1'h0;
        for (int i = 3; i >= 0; i--) begin
            for (int j = 3; j > i; j--) begin
                if (capture_copy[i] == capture_copy[j]) begin
                    agree  = 1'h1;
                    winner = capture_copy[i];
                end
            end
        end
        dec_hi = symbol_to_nibble(winner[11:6]);
        dec_lo = symbol_to_nibble(winner[5:0]);
        if (rx_edge) begin
            samp_en_next  = 1'h1;
            samp_cnt_next = '0;
        end else if (samp_en_reg) begin
            if (samp_cnt_reg == BIT_LAST) begin
                samp_cnt_next = '0;
            end else begin
                samp_cnt_next = samp_cnt_reg + 1'h1;
            end
            if (samp_cnt_reg == SAMPLE_LAST) begin
                rx_shift_next = shifted;
                if (shifted[35 -: 12] == rft_pkg::POSTAMBLE) begin
                    capture_next[cap_idx_reg] = shifted[rft_pkg::PAY_LSB +: 12];
                    rx_shift_next = '0;
                    cap_idx_next  = cap_idx_reg + 1'h1;
                end
            end
        end
        if (cap_idx_reg == 2'h0 && samp_en_reg && rx_shift_reg == '0
                && capture_copy[3] != '0) begin
            // fourth copy just landed: vote, then clear for the next group
            if (agree && dec_hi[4] && dec_lo[4]) begin
                rx_digits_next = '{hi: dec_hi[3:0], lo: dec_lo[3:0]};
                rx_update_next = 1'h1;
            end
            for (int k = 0; k < 4; k++) begin
                capture_next[k] = '0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_meta_reg     <= 1'h0;
            rx_sync_reg     <= 1'h0;
            rx_edge_history <= 3'h0;
            samp_en_reg     <= 1'h0;
            samp_cnt_reg    <= '0;
            rx_shift_reg    <= '0;
            cap_idx_reg     <= 2'h0;
            rx_digits       <= '0;
            rx_update       <= 1'h0;
            for (int k = 0; k < 4; k++) begin
                capture_copy[k] <= '0;
            end
        end else begin
            rx_meta_reg     <= rx_pin;
            rx_sync_reg     <= rx_meta_reg;
            rx_edge_history <= {rx_edge_history[1:0], rx_sync_reg};
            samp_en_reg     <= samp_en_next;
            samp_cnt_reg    <= samp_cnt_next;
            rx_shift_reg    <= rx_shift_next;
            cap_idx_reg     <= cap_idx_next;
            rx_digits       <= rx_digits_next;
            rx_update       <= rx_update_next;
            capture_copy    <= capture_next;
        end
    end

    // ---------------- mode selects and lcd ----------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_rf_mode      <= rft_pkg::TX_MODE_LEVEL;
            rx_rf_mode      <= rft_pkg::RX_MODE_LEVEL;
            lcd_common_line <= 1'h0;
        end else begin
            tx_rf_mode      <= rft_pkg::TX_MODE_LEVEL;
            rx_rf_mode      <= rft_pkg::RX_MODE_LEVEL;
            lcd_common_line <= lcd_reg;
        end
    end
endmodule

/* verification/rft_transceiver_sva.sv */
// checker: port-level assertions on the rf transceiver top
// assumes bind onto rft_transceiver, one clock, synchronous active-low reset
`timescale 1ns/1ps
module rft_transceiver_sva #(
    parameter int unsigned BIT_CYC      = 16,
    parameter int unsigned LCD_HALF_CYC = 50
) (
    input wire logic                 clk_sys,
    input wire logic                 rst_n,
    input wire logic                 rx_pin,
    input wire logic                 tx_pin,
    input wire logic                 tx_rf_mode,
    input wire logic                 rx_rf_mode,
    input wire logic                 lcd_common_line,
    input wire rft_pkg::rft_digits_t tx_digits,
    input wire rft_pkg::rft_digits_t rx_digits,
    input wire logic                 rx_update
);
    logic        tx_reg, lcd_reg, seen_reg, tx_next, lcd_next, seen_next;
    logic [19:0] tx_hold_reg, lcd_hold_reg, tx_hold_next, lcd_hold_next;

    // hold counters give the length of the run that a change ends
    always_comb begin
        tx_next       = tx_pin;
        lcd_next      = lcd_common_line;
        seen_next     = seen_reg | (lcd_common_line != lcd_reg);
        tx_hold_next  = (tx_pin != tx_reg) ? 20'h00001 : tx_hold_reg + 20'h00001;
        lcd_hold_next = (lcd_common_line != lcd_reg) ? 20'h00001 : lcd_hold_reg + 20'h00001;
        if (!rst_n) begin
            tx_next       = 1'h0;
            lcd_next      = 1'h0;
            seen_next     = 1'h0;
            tx_hold_next  = 20'h00000;
            lcd_hold_next = 20'h00000;
        end
    end

    always_ff @(posedge clk_sys) begin
        tx_reg       <= tx_next;
        lcd_reg      <= lcd_next;
        seen_reg     <= seen_next;
        tx_hold_reg  <= tx_hold_next;
        lcd_hold_reg <= lcd_hold_next;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_tx_mode_level: assert property (tx_rf_mode == rft_pkg::TX_MODE_LEVEL)
        else $error("tx mode level wrong");
    a_rx_mode_level: assert property (rx_rf_mode == rft_pkg::RX_MODE_LEVEL)
        else $error("rx mode level wrong");
    a_update_single: assert property (rx_update |=> !rx_update)
        else $error("update pulse longer than one cycle");
    a_digits_held: assert property ($changed(rx_digits) |->
        (rx_update || $past(rx_update)) or ##1 rx_update)
        else $error("rx digits changed without update");
    // idle gaps are exempt, so a stray long zero run in a frame slips past here
    a_bit_period: assert property ((tx_pin != tx_reg) |->
        (tx_hold_reg % BIT_CYC == 0) || (!tx_reg && tx_hold_reg > 4 * BIT_CYC))
        else $error("tx bit length not a whole bit period");
    a_run_limit: assert property ((tx_pin && tx_reg) |-> tx_hold_reg < 4 * BIT_CYC)
        else $error("more than four equal bits on tx");
    a_lcd_half: assert property (((lcd_common_line != lcd_reg) && seen_reg) |->
        lcd_hold_reg == LCD_HALF_CYC)
        else $error("lcd half period wrong");
    a_digits_at_frame: assert property ($changed(tx_digits) |=> $rose(tx_pin))
        else $error("tx digits changed outside frame start");
endmodule

bind rft_transceiver rft_transceiver_sva #(
    .BIT_CYC      (BIT_CYC),
    .LCD_HALF_CYC (LCD_HALF_CYC)
) rft_transceiver_sva_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .tx_rf_mode(tx_rf_mode), .rx_rf_mode(rx_rf_mode), .lcd_common_line(lcd_common_line),
    .tx_digits(tx_digits), .rx_digits(rx_digits), .rx_update(rx_update)
);

/* verification/rft_rf_link.sv */
// partner: the rf module pair seen as one link from tx data pin to rx data pin
// assumes frames start with a rising edge from idle and bits last BIT_CYC clocks
`timescale 1ns/1ps
module rft_rf_link #(
    parameter int unsigned BIT_CYC = 16
) (
    input  wire logic clk_sys,
    input  wire logic tx_data,
    input  wire logic tx_mode,
    input  wire logic rx_mode,
    input  wire logic flip_en,
    output logic      rx_data
);
    int unsigned pos    = 0;
    int unsigned fcount = 0;
    logic        in_frame = 1'b0;

    initial rx_data = 1'b0;

    // flips one payload bit per frame, a different one each frame, when asked
    always @(posedge clk_sys) begin
        if (!in_frame && tx_data) begin
            in_frame = 1'b1;
            pos      = 0;
        end
        if (tx_mode !== rft_pkg::TX_MODE_LEVEL || rx_mode !== rft_pkg::RX_MODE_LEVEL)
            rx_data <= ~rx_data;
        else
            rx_data <= tx_data ^ (flip_en && in_frame && pos / BIT_CYC == 12 + fcount % 12);
        if (in_frame) begin
            pos = pos + 1;
            if (pos == 36 * BIT_CYC) begin
                in_frame = 1'b0;
                fcount   = fcount + 1;
            end
        end
    end
endmodule

/* verification/rft_transceiver_bench.sv */
// bench: loopback through the link model, frame, repeat and vote checks
// assumes short timing parameters so nine display states fit one run
`timescale 1ns/1ps
module rft_transceiver_bench;
    localparam int unsigned BIT   = 16;
    localparam int unsigned GAP   = 700;
    localparam int unsigned DISP  = 4000;
    localparam int          LIMIT = 50000;

    logic                 clk_sys = 1'b0;
    logic                 rst_n   = 1'b0;
    logic                 flip_en = 1'b0;
    logic                 rx_pin, tx_pin, tx_rf_mode, rx_rf_mode, lcd_common_line, rx_update;
    rft_pkg::rft_digits_t tx_digits, rx_digits;
    logic                 upd_q   = 1'b0;
    logic [7:0]           exp_val = 8'h00;
    logic [35:0]          frame;
    int                   bad_count = 0, comparisons = 0, cyc = 0, upd_cnt = 0;
    int                   exp_upd = 0, start = 0, prev = 0, n = 0;

    rft_transceiver #(
        .BIT_CYC(BIT), .SAMPLE_CYC(12), .GAP_CYC(GAP), .DISPLAY_CYC(DISP), .LCD_HALF_CYC(50)
    ) rft_transceiver_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .rx_pin(rx_pin), .tx_pin(tx_pin),
        .tx_rf_mode(tx_rf_mode), .rx_rf_mode(rx_rf_mode), .lcd_common_line(lcd_common_line),
        .tx_digits(tx_digits), .rx_digits(rx_digits), .rx_update(rx_update)
    );

    rft_rf_link #(.BIT_CYC(BIT)) rft_rf_link_i (
        .clk_sys(clk_sys), .tx_data(tx_pin), .tx_mode(tx_rf_mode), .rx_mode(rx_rf_mode),
        .flip_en(flip_en), .rx_data(rx_pin)
    );

    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            end_of_test();
        end
    end

    // updates can land before a frame read ends, so they are counted apart
    always @(negedge clk_sys) begin
        if (upd_q)
            upd_cnt++;
        upd_q = rx_update;
    end

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // samples each bit at its middle; returns on the middle of the slot after bit 35
    task automatic read_frame(output logic [35:0] v, output int t0);
        int i;
        i = 0;
        v = '0;
        while (tx_pin !== 1'b1 && i < DISP + 100) begin
            @(negedge clk_sys);
            i++;
        end
        t0 = cyc;
        repeat (BIT / 2) @(negedge clk_sys);
        for (int b = 0; b < 36; b++) begin
            v[b] = tx_pin;
            repeat (BIT) @(negedge clk_sys);
        end
    endtask

    function automatic logic [35:0] exp_frame(input int k);
        return {rft_pkg::POSTAMBLE, rft_pkg::SYM_TABLE[2 * k], rft_pkg::SYM_TABLE[2 * k + 1],
                rft_pkg::PREAMBLE};
    endfunction

    initial begin
        repeat (11) @(negedge clk_sys);
        check({32'h0, tx_pin, rx_update, tx_rf_mode, rx_rf_mode}, 36'h2);
        @(posedge clk_sys) rst_n <= 1'b1;
        @(negedge clk_sys);
        // state 3 has one bad copy, state 4 three different bad copies
        for (int s = 1; s <= 9; s++) begin
            n = s % 8;
            for (int f = 0; f < 4; f++) begin
                @(posedge clk_sys) flip_en <= (s == 3 && f == 0) || (s == 4 && f < 3);
                @(negedge clk_sys);
                read_frame(frame, start);
                check(frame, exp_frame(n));
                check(36'(tx_pin), 36'(rft_pkg::LINE_IDLE));
                check(36'(tx_digits), {28'h0, 4'(2 * n), 4'(2 * n + 1)});
                if (s > 1)
                    check(36'(start - prev), 36'((f == 0) ? DISP - 3 * GAP : GAP));
                prev = start;
            end
            repeat (4) @(negedge clk_sys);
            if (s != 4) begin
                exp_upd++;
                exp_val = {4'(2 * n), 4'(2 * n + 1)};
            end
            check(36'(upd_cnt), 36'(exp_upd));
            check(36'(rx_digits), 36'(exp_val));
        end
        end_of_test();
    end
endmodule
